/* File: include/wdt_pkg.sv */
// package: watchdog register map, field positions, reset values, counts
package wdt_pkg;
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;
  localparam int REG_W = 8;
  localparam int CNT_W = 26;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CLK_CTRL  = 8'h8e;
  localparam logic [7:0] IDX_IRQ_EN    = 8'ha8;
  localparam logic [7:0] IDX_WDOG_CTRL = 8'hd8;
  localparam logic [7:0] IDX_EXT_IRQ   = 8'he8;
  localparam logic [7:0] IDX_TA_KEY    = 8'heb;
  localparam logic [7:0] IDX_EVT_STAT  = 8'hf0;
  localparam logic [7:0] IDX_EVT_CLR   = 8'hf1;
  localparam logic [7:0] IDX_EVT_EN    = 8'hf2;
  // reset values
  localparam logic [7:0] RST_CLK_CTRL  = 8'h07;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  // field positions
  localparam int SEL_LSB  = 6;
  localparam int WDC_RST  = 0;
  localparam int WDC_EWT  = 1;
  localparam int WDC_WATCHDOG_RESET_CAUSE = 2;
  localparam int WDC_WATCHDOG_TIMEOUT_FLAG = 3;
  localparam int EIE_WDI  = 5;
  localparam int IE_EA    = 7;
  localparam int EV_TMO   = 0;
  localparam int EV_RST   = 1;
  localparam int EV_N     = 2;
  // timed access key bytes
  localparam logic [7:0] KEY_FIRST  = 8'haa;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  // interval counts in operating clocks
  localparam int INTERVAL0 = 131072;
  localparam int INTERVAL1 = 1048576;
  localparam int INTERVAL2 = 8388608;
  localparam int INTERVAL3 = 67108864;
  // clocks from timeout flag to cpu reset
  localparam int RST_DELAY = 512;
  localparam logic [9:0] RST_DLY_LAST = 10'(RST_DELAY - 1);
  // clock rate, for reference of real-time period
  localparam int CLK_NS = 40;
  typedef enum logic [1:0] {
    TA_IDLE,
    TA_GOT_FIRST,
    TA_OPEN
  } wdt_ta_t;
endpackage

/* File: rtl/wdt_core.sv */
// watchdog timer core with classic wishbone register slave
`timescale 1ns/1ps
module wdt_core #(
  parameter int INT0 = wdt_pkg::INTERVAL0,
  parameter int INT1 = wdt_pkg::INTERVAL1,
  parameter int INT2 = wdt_pkg::INTERVAL2,
  parameter int INT3 = wdt_pkg::INTERVAL3
) (
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst,
  input  wire logic                      i_wb_cyc,
  input  wire logic                      i_wb_stb,
  input  wire logic                      i_wb_we,
  input  wire logic [wdt_pkg::ADR_W-1:0] i_wb_adr,
  input  wire logic [3:0]                i_wb_sel,
  input  wire logic [wdt_pkg::DAT_W-1:0] i_wb_dat,
  output logic      [wdt_pkg::DAT_W-1:0] o_wb_dat,
  output logic                           o_wb_ack,
  output logic                           o_wdt_irq,
  output logic                           o_cpu_rst,
  output logic                           o_irq
);
  import wdt_pkg::*;

  logic             ack_q;
  logic [7:0]       rdat_q;
  logic [7:0]       clk_ctrl_q;
  logic             irq_en_q;
  logic             ext_en_q;
  logic             ewt_q;
  logic             restart_q;
  logic             flag_q;
  logic             cause_q;
  logic [CNT_W-1:0] cnt_q;
  logic             pend_q;
  logic [9:0]       dly_q;
  logic             cpu_rst_q;
  logic             wdt_irq_q;
  logic [EV_N-1:0]  stat_q;
  logic [EV_N-1:0]  ev_en_q;
  wdt_ta_t          ta_q;
  wdt_ta_t          ta_d;

  // bus decode
  wire       req      = i_wb_cyc & i_wb_stb;
  wire       wr       = req & i_wb_we & ack_q & i_wb_sel[0];
  wire [7:0] idx      = i_wb_adr[9:2];
  wire [7:0] wbyte    = i_wb_dat[7:0];
  wire       hit_ckc  = idx == IDX_CLK_CTRL;
  wire       hit_ie   = idx == IDX_IRQ_EN;
  wire       hit_wdc  = idx == IDX_WDOG_CTRL;
  wire       hit_eie  = idx == IDX_EXT_IRQ;
  wire       hit_ta   = idx == IDX_TA_KEY;
  wire       hit_st   = idx == IDX_EVT_STAT;
  wire       hit_clr  = idx == IDX_EVT_CLR;
  wire       hit_en   = idx == IDX_EVT_EN;
  wire       wr_wdc   = wr & hit_wdc;
  wire       ta_open  = ta_q == TA_OPEN;
  wire       wr_prot  = wr_wdc & ta_open;
  wire       sw_rst   = wr_prot & wbyte[WDC_RST];

  // interval select
  wire [1:0] sel = clk_ctrl_q[SEL_LSB+1:SEL_LSB];
  logic [CNT_W-1:0] last;
  always_comb begin
    case (sel)
      2'd0:    last = CNT_W'(INT0 - 1);
      2'd1:    last = CNT_W'(INT1 - 1);
      2'd2:    last = CNT_W'(INT2 - 1);
      default: last = CNT_W'(INT3 - 1);
    endcase
  end

  // one count per operating clock, tick at the last count of the interval
  wire tick    = cnt_q == last;
  wire dly_end = pend_q & (dly_q == RST_DLY_LAST);
  wire wd_rst  = dly_end & ~restart_q;

  // read mux
  logic [7:0] rd_mux;
  always_comb begin
    if (hit_ckc) begin
      rd_mux = clk_ctrl_q;
    end else if (hit_ie) begin
      rd_mux = {irq_en_q, 7'h00};
    end else if (hit_wdc) begin
      rd_mux = {4'h0, flag_q, cause_q, ewt_q, restart_q};
    end else if (hit_eie) begin
      rd_mux = {2'b00, ext_en_q, 5'h00};
    end else if (hit_st) begin
      rd_mux = {6'h00, stat_q};
    end else if (hit_en) begin
      rd_mux = {6'h00, ev_en_q};
    end else begin
      rd_mux = 8'h00; // unmapped, key and clear read zero
    end
  end

  // timed access sequencer: any bus write other than the key closes it
  always_comb begin
    ta_d = ta_q;
    if (wr) begin
      if (hit_ta && wbyte == KEY_FIRST) begin
        ta_d = TA_GOT_FIRST;
      end else if (hit_ta && wbyte == KEY_SECOND && ta_q == TA_GOT_FIRST) begin
        ta_d = TA_OPEN;
      end else begin
        ta_d = TA_IDLE;
      end
    end
  end

  // bus slave: ack one cycle after request, dropped the cycle after
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ack_q  <= 1'b0;
      rdat_q <= RST_ZERO;
      ta_q   <= TA_IDLE;
    end else begin
      ack_q  <= req & ~ack_q;
      rdat_q <= rd_mux;
      ta_q   <= ta_d;
    end
  end

  // plain configuration registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      clk_ctrl_q <= RST_CLK_CTRL;
      irq_en_q   <= 1'b0;
      ext_en_q   <= 1'b0;
      ev_en_q    <= '0;
    end else begin
      if (wr && hit_ckc) begin
        clk_ctrl_q <= wbyte;
      end
      if (wr && hit_ie) begin
        irq_en_q <= wbyte[IE_EA];
      end
      if (wr && hit_eie) begin
        ext_en_q <= wbyte[EIE_WDI];
      end
      if (wr && hit_en) begin
        ev_en_q <= wbyte[EV_N-1:0];
      end
    end
  end

  // protected control bits; a watchdog reset leaves the enable set
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ewt_q     <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      if (wr_prot) begin
        ewt_q <= wbyte[WDC_EWT];
      end
      restart_q <= sw_rst;
    end
  end

  // free-running counter
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (tick || restart_q || wd_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // timeout flag: set wins over a software clear in the same cycle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      flag_q <= 1'b0;
    end else if (tick) begin
      flag_q <= 1'b1;
    end else if (wd_rst) begin
      flag_q <= 1'b0;
    end else if (wr_wdc) begin
      flag_q <= wbyte[WDC_WATCHDOG_TIMEOUT_FLAG];
    end
  end

  // reset cause: software write of one sets no reset
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cause_q <= 1'b0;
    end else if (wd_rst) begin
      cause_q <= 1'b1;
    end else if (wr_wdc) begin
      cause_q <= wbyte[WDC_WATCHDOG_RESET_CAUSE];
    end
  end

  // reset delay after the flag; restart cancels it
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pend_q <= 1'b0;
      dly_q  <= '0;
    end else if (restart_q || wd_rst) begin
      pend_q <= 1'b0;
      dly_q  <= '0;
    end else if (tick && ewt_q) begin
      pend_q <= 1'b1;
      dly_q  <= '0;
    end else if (pend_q) begin
      dly_q  <= dly_q + 1'b1;
    end
  end

  // outputs to the cpu core, registered
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cpu_rst_q <= 1'b0;
      wdt_irq_q <= 1'b0;
    end else begin
      cpu_rst_q <= wd_rst;
      wdt_irq_q <= flag_q & ext_en_q & irq_en_q;
    end
  end

  // sticky event status, set wins over clear
  wire [EV_N-1:0] ev_set = {wd_rst, tick};
  wire [EV_N-1:0] ev_clr = (wr && hit_clr) ? wbyte[EV_N-1:0] : '0;
  genvar g;
  generate
    for (g = 0; g < EV_N; g++) begin : g_ev
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          stat_q[g] <= 1'b0;
        end else if (ev_set[g]) begin
          stat_q[g] <= 1'b1;
        end else if (ev_clr[g]) begin
          stat_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign o_wb_ack  = ack_q;
  assign o_wb_dat  = {24'h000000, rdat_q};
  assign o_cpu_rst = cpu_rst_q;
  assign o_wdt_irq = wdt_irq_q;
  assign o_irq     = |(stat_q & ev_en_q);

  // helper: clocks since the flag was raised while a reset is pending
  logic [9:0] age_q;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      age_q <= '0;
    end else if (tick) begin
      age_q <= '0;
    end else if (age_q != 10'h3ff) begin
      age_q <= age_q + 1'b1;
    end
  end

  property p_free_run;
    @(posedge i_mclk) disable iff (i_rst)
    (tick && !ewt_q && !ext_en_q) |=> flag_q;
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("flag not set on timeout");
  property p_interval;
    @(posedge i_mclk) disable iff (i_rst)
    (sel == 2'd0 && cnt_q == CNT_W'(INT0 - 1)) ||
    (sel == 2'd3 && cnt_q == CNT_W'(INT3 - 1)) |-> tick;
  endproperty
  a_interval: assert property (p_interval)
    else $error("timeout at wrong count");
  property p_restart;
    @(posedge i_mclk) disable iff (i_rst)
    sw_rst |=> restart_q ##1 (cnt_q == '0);
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not clear count");
  property p_flag_hold;
    @(posedge i_mclk) disable iff (i_rst)
    (flag_q && !wd_rst && !(wr_wdc && !wbyte[WDC_WATCHDOG_TIMEOUT_FLAG])) |=> flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag lost without clear");
  property p_cpu_irq;
    @(posedge i_mclk) disable iff (i_rst)
    o_wdt_irq |-> $past(flag_q) && $past(ext_en_q) && $past(irq_en_q);
  endproperty
  a_cpu_irq: assert property (p_cpu_irq)
    else $error("irq without enables");
  property p_rst_delay;
    @(posedge i_mclk) disable iff (i_rst)
    o_cpu_rst |-> ($past(age_q) == RST_DLY_LAST) && $past(ewt_q);
  endproperty
  a_rst_delay: assert property (p_rst_delay)
    else $error("cpu reset at wrong time");

  property p_self_clear;
    @(posedge i_mclk) disable iff (i_rst)
    restart_q |=> !restart_q;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("restart bit stuck");
  property p_cause;
    @(posedge i_mclk) disable iff (i_rst)
    o_cpu_rst |-> cause_q && !flag_q;
  endproperty
  a_cause: assert property (p_cause)
    else $error("cause not set on reset");

  property p_rst_restart;
    @(posedge i_mclk) disable iff (i_rst)
    o_cpu_rst |-> (cnt_q == '0) && (ewt_q == $past(ewt_q));
  endproperty
  a_rst_restart: assert property (p_rst_restart)
    else $error("watchdog not restarted");

  property p_protect;
    @(posedge i_mclk) disable iff (i_rst)
    (wr_wdc && !ta_open) |=> (ewt_q == $past(ewt_q)) && !restart_q;
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected write without key");
endmodule

/* File: sim/wdt_cpu_model.sv */
// cpu side model: takes watchdog resets, times them from the irq edge
`timescale 1ns/1ps
module wdt_cpu_model (
  input  wire logic i_mclk,
  input  wire logic i_wdt_irq,
  input  wire logic i_cpu_rst,
  output int        o_rst_cnt,
  output int        o_gap
);
  int since;
  initial begin
    o_rst_cnt = 0;
    o_gap = 0;
    since = 0;
  end
  // irq is one clock behind the flag, so the gap is one short of the delay
  always @(posedge i_mclk) begin
    since <= i_wdt_irq ? since + 1 : 0;
    if (i_cpu_rst) begin
      o_rst_cnt <= o_rst_cnt + 1;
      o_gap <= since;
    end
  end
endmodule

/* File: sim/wdt_core_tb.sv */
// self-checking bench for the watchdog core
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: %h not %h", $time, (a), (e)); end end
module wdt_core_tb;
  import wdt_pkg::*;
  localparam int IV [4] = '{1024, 2048, 4096, 8192};
  logic        i_mclk, i_rst, cyc, stb, we, ack, wdt_irq, cpu_rst, irq;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [7:0]  rd;
  int          errors, checks, rst_cnt, gap, n;

  wdt_core #(.INT0(IV[0]), .INT1(IV[1]), .INT2(IV[2]), .INT3(IV[3])) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_wdt_irq(wdt_irq),
    .o_cpu_rst(cpu_rst), .o_irq(irq));
  wdt_cpu_model cpu (.i_mclk(i_mclk), .i_wdt_irq(wdt_irq),
    .i_cpu_rst(cpu_rst), .o_rst_cnt(rst_cnt), .o_gap(gap));

  initial begin
    i_mclk = 1'h0;
    forever #20 i_mclk = ~i_mclk;
  end

  task end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one classic cycle; held until ack is sampled high
  task wb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    int k;
    @(posedge i_mclk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= {24'h0, d};
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while (ack !== 1'h1 && k < 20);
    if (k >= 20) begin
      errors++;
      end_sim();
    end
    rd = rdat[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  task rdchk(input logic [7:0] idx, input logic [7:0] e);
    wb(idx, 1'h0, 8'h00);
    `CHK(rd, e)
  endtask

  task unlock;
    wb(IDX_TA_KEY, 1'h1, KEY_FIRST);
    wb(IDX_TA_KEY, 1'h1, KEY_SECOND);
  endtask

  // bounded wait on a cpu reset count or on the irq line
  task wait_on(input int c, input int lim);
    n = 0;
    while ((c < 0 ? wdt_irq !== 1'h1 : rst_cnt != c) && n < lim) begin
      @(posedge i_mclk);
      n++;
    end
    if (n >= lim) begin
      errors++;
      end_sim();
    end
  endtask

  initial begin
    errors = 0;
    checks = 0;
    i_rst = 1'h1;
    {cyc, stb, we, adr, wdat} = '0;
    sel = 4'hf;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'h0;
    rdchk(IDX_CLK_CTRL, RST_CLK_CTRL);
    rdchk(IDX_WDOG_CTRL, RST_ZERO);
    rdchk(8'h10, 8'h00);
    $display("test reset values done");
    // free-running flag at every interval, no enables on
    for (int s = 0; s < 4; s++) begin
      wb(IDX_CLK_CTRL, 1'h1, {2'(s), 6'h07});
      unlock();
      wb(IDX_WDOG_CTRL, 1'h1, 8'h01);
      rdchk(IDX_WDOG_CTRL, 8'h00);
      repeat (IV[s] - 40) @(posedge i_mclk);
      rdchk(IDX_WDOG_CTRL, 8'h00);
      repeat (40) @(posedge i_mclk);
      rdchk(IDX_WDOG_CTRL, 8'h08);
    end
    $display("test intervals done");
    wb(IDX_CLK_CTRL, 1'h1, 8'h07);
    unlock();
    wb(IDX_WDOG_CTRL, 1'h1, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wb(IDX_EXT_IRQ, 1'h1, {2'h0, m[0], 5'h00});
      wb(IDX_IRQ_EN, 1'h1, {m[1], 7'h00});
      wb(IDX_WDOG_CTRL, 1'h1, 8'h08);
      repeat (2) @(posedge i_mclk);
      `CHK(wdt_irq, 1'(m == 3))
    end
    wb(IDX_WDOG_CTRL, 1'h1, 8'h00);
    repeat (2) @(posedge i_mclk);
    `CHK(wdt_irq, 1'h0)
    $display("test irq gating done");
    // sticky event, masked, unmasked, then cleared
    rdchk(IDX_EVT_STAT, 8'h01);
    `CHK(irq, 1'h0)
    wb(IDX_EVT_EN, 1'h1, 8'h01);
    repeat (2) @(posedge i_mclk);
    `CHK(irq, 1'h1)
    wb(IDX_EVT_CLR, 1'h1, 8'h01);
    repeat (2) @(posedge i_mclk);
    `CHK(irq, 1'h0)
    $display("test event irq done");
    // cpu reset armed, taken twice, then cancelled by a restart
    unlock();
    wb(IDX_WDOG_CTRL, 1'h1, 8'h03);
    wait_on(1, 2000);
    `CHK(gap, RST_DELAY - 1)
    rdchk(IDX_WDOG_CTRL, 8'h06);
    rdchk(IDX_EVT_STAT, 8'h03);
    wait_on(2, 2000);
    `CHK(gap, RST_DELAY - 1)
    wait_on(-1, 1200);
    unlock();
    wb(IDX_WDOG_CTRL, 1'h1, 8'h03);
    repeat (600) @(posedge i_mclk);
    `CHK(rst_cnt, 2)
    $display("test cpu reset done");
    // a stray write between the key bytes leaves the bits locked
    wb(IDX_TA_KEY, 1'h1, KEY_FIRST);
    wb(IDX_IRQ_EN, 1'h1, 8'h80);
    wb(IDX_TA_KEY, 1'h1, KEY_SECOND);
    wb(IDX_WDOG_CTRL, 1'h1, 8'h00);
    rdchk(IDX_WDOG_CTRL, 8'h02);
    unlock();
    wb(IDX_WDOG_CTRL, 1'h1, 8'h00);
    rdchk(IDX_WDOG_CTRL, 8'h00);
    $display("test key done");
    end_sim();
  end
endmodule
